// ==== verilog/fefc_top.sv ====
// fpu exception flag and mask control with ahb-lite register access
//
// The AHB-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
module fefc_top
  import fefc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // instruction from the stream
  input wire logic insnValid,
  input wire fefc_op_t insnOp,
  input wire logic insnNoWait,
  input wire fefc_fmt_t insnFmt,
  input wire logic insnSrcRead,
  input wire logic [1:0] insnSrcTag,
  input wire logic insnDstLoad,
  input wire logic [1:0] insnDstTag,
  input wire logic [NUM_EXC-1:0] insnExc,
  input wire logic [WORD_W-1:0] insnCtrlIn,
  input wire logic [WORD_W-1:0] insnStatusIn,
  // results to the stream
  output logic insnDone,
  output logic serviceReq,
  output logic keepStack,
  output logic storeValid,
  output logic [WORD_W-1:0] ctrlWordOut,
  output logic [WORD_W-1:0] statusWordOut,
  // interrupt
  output logic irq
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [WORD_W-1:0] cw;
    logic [WORD_W-1:0] sw;
    logic [NUM_EV-1:0] ien;
    fefc_bus_t bus;
    logic [ADDR_W-1:0] busAddr;
    logic busWrite;
    logic busOk;
    logic hreadyout;
    logic [31:0] hrdata;
    logic insnDone;
    logic serviceReq;
    logic keepStack;
    logic storeValid;
    logic [WORD_W-1:0] ctrlOut;
    logic [WORD_W-1:0] statusOut;
    logic irq;
  } fefc_state_t;

  localparam fefc_state_t ST_RESET = '{
    cw: CW_RESET,
    sw: SW_RESET,
    ien: '0,
    bus: BUS_IDLE,
    busAddr: '0,
    busWrite: 1'b0,
    busOk: 1'b0,
    hreadyout: 1'b1,
    hrdata: '0,
    insnDone: 1'b0,
    serviceReq: 1'b0,
    keepStack: 1'b0,
    storeValid: 1'b0,
    ctrlOut: '0,
    statusOut: '0,
    irq: 1'b0
  };

  fefc_state_t st_r;
  fefc_state_t st_nxt;

  // ==========================================================
  // instruction decode
  logic isOperandOp;
  logic isArith;
  logic twoForm;
  logic isLegacy;
  logic waitExempt;
  logic pending;
  logic blocked;
  logic execNow;
  logic stkUnder;
  logic stkOver;
  logic stkFault;
  logic invRaised;
  logic invUnmasked;
  logic [NUM_EXC-1:0] excRaised;

  assign isOperandOp = insnOp inside {OP_ARITH, OP_NONARITH,
                                      OP_LOAD_OPERAND, OP_STORE_OPERAND};
  // single and double moves convert, extended and register moves do not
  assign isArith = (insnOp == OP_ARITH) ||
                   ((insnOp inside {OP_LOAD_OPERAND, OP_STORE_OPERAND}) &&
                    (insnFmt inside {FMT_SINGLE, FMT_DOUBLE}));
  assign twoForm = insnOp inside {OP_STORE_CW, OP_STORE_SW, OP_SAVE,
                                  OP_INIT, OP_CLEAR};
  assign isLegacy = insnOp inside {OP_LEGACY_EN, OP_LEGACY_DIS,
                                   OP_LEGACY_PM};
  assign waitExempt = isLegacy || (twoForm && insnNoWait);
  assign pending = |(st_r.sw[NUM_EXC-1:0] &
                     ~st_r.cw[NUM_EXC-1:0]);
  assign blocked = insnValid && !waitExempt && pending;
  assign execNow = insnValid && !blocked;
  assign stkUnder = isOperandOp && insnSrcRead &&
                    (insnSrcTag == TAG_EMPTY);
  assign stkOver = isOperandOp && insnDstLoad &&
                   (insnDstTag != TAG_EMPTY);
  assign stkFault = stkUnder || stkOver;
  // operand-related classes only reach the flags from arithmetic ops
  assign excRaised = isArith ? insnExc : '0;
  assign invRaised = stkFault || excRaised[EXC_INV];
  assign invUnmasked = isOperandOp && invRaised &&
                       !st_r.cw[CW_INV_MASK_BIT];

  // ==========================================================
  // register read and interrupt status
  logic busWrEn;
  logic [31:0] rdValue;
  logic [NUM_EV-1:0] evSet;
  logic [NUM_EV-1:0] evClr;
  logic [NUM_EV-1:0] evBits;

  assign busWrEn = (st_r.bus == BUS_DATA) && st_r.busWrite && st_r.busOk;
  assign rdValue = (st_r.busAddr == ADDR_CTRL) ? 32'(st_r.cw) :
                   (st_r.busAddr == ADDR_STATUS) ? 32'(st_r.sw) :
                   (st_r.busAddr == ADDR_ISTAT) ? 32'(evBits) :
                   (st_r.busAddr == ADDR_IEN) ? 32'(st_r.ien) : '0;

  assign evSet[EV_SERVICE] = blocked || (execNow && invUnmasked);
  assign evSet[EV_STACK] = execNow && stkFault;
  assign evSet[EV_EXC] = execNow && ((excRaised != '0) || stkFault);
  assign evClr = (busWrEn && (st_r.busAddr == ADDR_ICLR)) ?
                 hwdata[NUM_EV-1:0] : '0;

  fefc_sticky #(
    .WIDTH(NUM_EV)
  ) u_events (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .setBits(evSet),
    .clrBits(evClr),
    .bits(evBits)
  );

  // ==========================================================
  // next state
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.insnDone = 1'b0;
    st_nxt.serviceReq = 1'b0;
    st_nxt.keepStack = 1'b0;
    st_nxt.storeValid = 1'b0;
    // one wait state per transfer keeps reads behind earlier writes
    case (st_r.bus)
      BUS_IDLE:
      begin
        if (hsel && hready && (htrans == HTRANS_NONSEQ))
        begin
          st_nxt.bus = BUS_DATA;
          st_nxt.busAddr = haddr[ADDR_W-1:0];
          st_nxt.busWrite = hwrite;
          st_nxt.busOk = (hsize == HSIZE_WORD);
          st_nxt.hreadyout = 1'b0;
        end
      end
      BUS_DATA:
      begin
        st_nxt.bus = BUS_IDLE;
        st_nxt.hreadyout = 1'b1;
        st_nxt.hrdata = (st_r.busWrite || !st_r.busOk) ? '0 : rdValue;
      end
      default:
      begin
        st_nxt.bus = BUS_IDLE;
        st_nxt.hreadyout = 1'b1;
      end
    endcase
    if (busWrEn && (st_r.busAddr == ADDR_CTRL))
      st_nxt.cw = hwdata[WORD_W-1:0];
    if (busWrEn && (st_r.busAddr == ADDR_STATUS))
      st_nxt.sw = st_r.sw & ~(hwdata[WORD_W-1:0] & SW_W1C_MASK);
    if (busWrEn && (st_r.busAddr == ADDR_IEN))
      st_nxt.ien = hwdata[NUM_EV-1:0];
    // instruction effects follow the bus so a flag set wins its clear
    if (blocked)
      st_nxt.serviceReq = 1'b1;
    else if (execNow)
    begin
      st_nxt.insnDone = 1'b1;
      case (insnOp)
        OP_LOAD_CW:
          st_nxt.cw = insnCtrlIn;
        OP_RESTORE, OP_XRESTORE:
        begin
          st_nxt.cw = insnCtrlIn;
          st_nxt.sw = insnStatusIn;
        end
        OP_STORE_CW:
        begin
          st_nxt.ctrlOut = st_r.cw;
          st_nxt.storeValid = 1'b1;
        end
        OP_STORE_SW:
        begin
          st_nxt.statusOut = st_r.sw;
          st_nxt.storeValid = 1'b1;
        end
        OP_SAVE, OP_XSAVE:
        begin
          st_nxt.ctrlOut = st_r.cw;
          st_nxt.statusOut = st_r.sw;
          st_nxt.storeValid = 1'b1;
          if (insnOp == OP_SAVE)
          begin
            st_nxt.cw = CW_RESET;
            st_nxt.sw = SW_RESET;
          end
        end
        OP_INIT:
        begin
          st_nxt.cw = CW_RESET;
          st_nxt.sw = SW_RESET;
        end
        OP_CLEAR:
          st_nxt.sw = st_nxt.sw & ~SW_CLR_MASK;
        OP_ARITH, OP_NONARITH, OP_LOAD_OPERAND, OP_STORE_OPERAND:
        begin
          // flag index equals class index, invalid first
          st_nxt.sw[NUM_EXC-1:0] = st_nxt.sw[NUM_EXC-1:0] |
                                   excRaised;
          if (stkFault)
          begin
            st_nxt.sw[SW_INV_BIT] = 1'b1;
            st_nxt.sw[SW_STKFLT_BIT] = 1'b1;
            st_nxt.sw[SW_CC1_BIT] = stkOver;
          end
          // stack fault flag untouched on a plain invalid operand
          if (invUnmasked)
          begin
            st_nxt.serviceReq = 1'b1;
            st_nxt.keepStack = 1'b1;
          end
        end
        default:
        begin
          // legacy opcodes and the check op leave the control and status words alone
          st_nxt.cw = st_nxt.cw;
        end
      endcase
    end
    st_nxt.sw[SW_SUMMARY_BIT] = |st_nxt.sw[NUM_EXC-1:0];
    st_nxt.irq = |(evBits & st_r.ien);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= ST_RESET;
    else
      st_r <= st_nxt;
  end

  // ==========================================================
  // outputs
  assign hrdata = st_r.hrdata;
  assign hreadyout = st_r.hreadyout;
  assign hresp = HRESP_OKAY;
  assign insnDone = st_r.insnDone;
  assign serviceReq = st_r.serviceReq;
  assign keepStack = st_r.keepStack;
  assign storeValid = st_r.storeValid;
  assign ctrlWordOut = st_r.ctrlOut;
  assign statusWordOut = st_r.statusOut;
  assign irq = st_r.irq;

  // ==========================================================
  // checks
  default clocking cb_sys @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence seq_bus_addr;
    hsel && hreadyout && (htrans == HTRANS_NONSEQ);
  endsequence

  sequence seq_bus_answer;
    !hreadyout ##1 hreadyout;
  endsequence

  chk_bus_timing: assert property (@(posedge sys_clk) disable iff (!rst_n)
    seq_bus_addr |=> seq_bus_answer)
    else $error("bus answer not after one wait state");

  chk_wait_blocks: assert property (
    (insnValid && !waitExempt && pending) |=> (serviceReq && !insnDone))
    else $error("waiting op ran over a pending exception");

  chk_nowait_runs: assert property (
    (insnValid && twoForm && insnNoWait) |=> insnDone)
    else $error("non-waiting op did not proceed");

  chk_legacy_noop: assert property (
    (insnValid && isLegacy && !busWrEn) |=>
      ($stable(st_r.cw) && $stable(st_r.sw) && !serviceReq))
    else $error("legacy opcode changed state");

  chk_stack_sets: assert property (
    (execNow && stkFault) |=>
      (st_r.sw[SW_STKFLT_BIT] && st_r.sw[SW_INV_BIT]))
    else $error("stack fault did not set its flags");

  chk_cc1_dir: assert property (
    (execNow && stkFault) |=> (st_r.sw[SW_CC1_BIT] == $past(stkOver)))
    else $error("condition bit wrong after stack fault");

  chk_ia_keeps_sf: assert property (
    (execNow && isArith && insnExc[EXC_INV] && !stkFault && !busWrEn) |=>
      (st_r.sw[SW_STKFLT_BIT] == $past(st_r.sw[SW_STKFLT_BIT])))
    else $error("invalid operand changed stack fault flag");

  chk_nonarith_quiet: assert property (
    (execNow && isOperandOp && !isArith && !busWrEn) |=>
      (st_r.sw[NUM_EXC-1:EXC_DENORM] ==
       $past(st_r.sw[NUM_EXC-1:EXC_DENORM])))
    else $error("non-arithmetic op raised operand exception");

  chk_summary_flag: assert property (
    st_r.sw[SW_SUMMARY_BIT] == (|st_r.sw[NUM_EXC-1:0]))
    else $error("summary flag disagrees with flags");

  chk_inv_handler: assert property (
    (execNow && invUnmasked) |=> (serviceReq && keepStack && insnDone))
    else $error("unmasked invalid op not sent to handler");

endmodule

// ==== verilog/fefc_pkg.sv ====
// shared constants and types of the fpu exception flag control block
package fefc_pkg;

  // ==========================================================
  // exception classes and word layouts
  localparam int NUM_EXC = 6;
  localparam int EXC_INV = 0;
  localparam int EXC_DENORM = 1;
  localparam int EXC_ZDIV = 2;
  localparam int EXC_OVF = 3;
  localparam int EXC_UNF = 4;
  localparam int EXC_PREC = 5;
  localparam int WORD_W = 16;
  localparam int SW_INV_BIT = 0;
  localparam int SW_STKFLT_BIT = 6;
  localparam int SW_SUMMARY_BIT = 7;
  localparam int SW_CC1_BIT = 9;
  localparam int CW_INV_MASK_BIT = 0;
  localparam logic [15:0] CW_RESET = 16'h003f;
  localparam logic [15:0] SW_RESET = 16'h0000;
  localparam logic [15:0] SW_CLR_MASK = 16'h00ff;
  localparam logic [15:0] SW_W1C_MASK = 16'h02ff;
  localparam logic [1:0] TAG_EMPTY = 2'h3;

  // ==========================================================
  // register map and bus codes
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ISTAT = 8'h08;
  localparam logic [7:0] ADDR_IEN = 8'h0c;
  localparam logic [7:0] ADDR_ICLR = 8'h10;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic HRESP_OKAY = 1'h0;

  // ==========================================================
  // interrupt events
  localparam int NUM_EV = 3;
  localparam int EV_SERVICE = 0;
  localparam int EV_STACK = 1;
  localparam int EV_EXC = 2;

  // ==========================================================
  // types
  typedef enum logic [4:0] {
    OP_ARITH, OP_NONARITH, OP_LOAD_OPERAND, OP_STORE_OPERAND,
    OP_CHECK, OP_LOAD_CW, OP_STORE_CW, OP_STORE_SW, OP_SAVE,
    OP_RESTORE, OP_XSAVE, OP_XRESTORE, OP_INIT, OP_CLEAR,
    OP_LEGACY_EN, OP_LEGACY_DIS, OP_LEGACY_PM
  } fefc_op_t;

  typedef enum logic [1:0] {
    FMT_REG, FMT_EXT, FMT_SINGLE, FMT_DOUBLE
  } fefc_fmt_t;

  typedef enum logic {BUS_IDLE, BUS_DATA} fefc_bus_t;

endpackage

// ==== verilog/fefc_sticky.sv ====
// sticky event bits with set-over-clear priority
`timescale 1ns/1ns
module fefc_sticky
  import fefc_pkg::*;
#(
  parameter int WIDTH = NUM_EV
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // event and clear strobes
  input wire logic [WIDTH-1:0] setBits,
  input wire logic [WIDTH-1:0] clrBits,
  // sticky state
  output logic [WIDTH-1:0] bits
);

  // ==========================================================
  // elaboration check
  if (WIDTH < 1)
  begin : g_bad_width
    $error("fefc_sticky needs WIDTH of at least one");
  end

  // ==========================================================
  // state
  typedef struct packed {
    logic [WIDTH-1:0] bits;
  } fefc_stk_state_t;

  fefc_stk_state_t st_r;
  fefc_stk_state_t st_nxt;

  // an event in the clearing cycle must survive
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.bits = (st_r.bits & ~clrBits) | setBits;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign bits = st_r.bits;

  // ==========================================================
  // checks
  chk_set_wins: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (setBits != '0) |=> ((bits & $past(setBits)) == $past(setBits)))
    else $error("event lost in sticky bits");

  chk_clear_acts: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ((clrBits & ~setBits) != '0) |=>
      ((bits & $past(clrBits & ~setBits)) == '0))
    else $error("sticky bit not cleared");

endmodule

// ==== test/fefc_stream_model.sv ====
// instruction stream model that presents one instruction per call
`timescale 1ns/1ns
module fefc_stream_model
  import fefc_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // instruction to the block
  output logic insnValid,
  output fefc_op_t insnOp,
  output logic insnNoWait,
  output fefc_fmt_t insnFmt,
  output logic insnSrcRead,
  output logic [1:0] insnSrcTag,
  output logic insnDstLoad,
  output logic [1:0] insnDstTag,
  output logic [NUM_EXC-1:0] insnExc,
  output logic [WORD_W-1:0] insnCtrlIn,
  output logic [WORD_W-1:0] insnStatusIn
);
  initial
  begin
    insnValid = 1'b0;
    insnOp = OP_CHECK;
    insnFmt = FMT_REG;
    {insnNoWait, insnSrcRead, insnSrcTag, insnDstLoad, insnDstTag} = '0;
    {insnExc, insnCtrlIn, insnStatusIn} = '0;
  end

  // ========================================
  // one instruction, taken at the next edge
  task automatic issue(input fefc_op_t op, input logic nw,
    input fefc_fmt_t fmt, input logic [5:0] stk, input logic [5:0] exc,
    input logic [15:0] cin, input logic [15:0] sin);
    @(posedge sys_clk);
    insnValid <= 1'b1;
    insnOp <= op;
    insnFmt <= fmt;
    {insnNoWait, insnSrcRead, insnSrcTag, insnDstLoad, insnDstTag} <= {nw, stk};
    {insnExc, insnCtrlIn, insnStatusIn} <= {exc, cin, sin};
    @(posedge sys_clk);
    insnValid <= 1'b0;
    // stale qualifiers are scrambled so they cannot be mistaken for live ones
    {insnExc, insnCtrlIn, insnStatusIn} <= ~{exc, cin, sin};
  endtask
endmodule

// ==== test/fefc_top_tb_top.sv ====
// self-checking bench of the fpu exception flag control block
`timescale 1ns/1ns
`define CHK(nm, e, g) \
  begin \
    testsRun++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("Error %s expected %h seen %h", nm, e, g); \
    end \
  end
module fefc_top_tb_top
  import fefc_pkg::*;
;
  logic sys_clk, rst_n, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans, insnSrcTag, insnDstTag;
  logic [2:0] hsize, mIstat, mIen, busSize;
  logic insnValid, insnNoWait, insnSrcRead, insnDstLoad;
  logic insnDone, serviceReq, keepStack, storeValid;
  fefc_op_t insnOp;
  fefc_fmt_t insnFmt;
  logic [5:0] insnExc;
  logic [15:0] insnCtrlIn, insnStatusIn, ctrlWordOut, statusWordOut, mCw, mSw;
  integer miscompares, testsRun, seed, i;

  fefc_top u_fefc_top (.sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .insnValid, .insnOp, .insnNoWait, .insnFmt, .insnSrcRead, .insnSrcTag,
    .insnDstLoad, .insnDstTag, .insnExc, .insnCtrlIn, .insnStatusIn,
    .insnDone, .serviceReq, .keepStack, .storeValid, .ctrlWordOut,
    .statusWordOut, .irq);
  fefc_stream_model u_fefc_stream_model (.sys_clk, .insnValid, .insnOp,
    .insnNoWait, .insnFmt, .insnSrcRead, .insnSrcTag, .insnDstLoad,
    .insnDstTag, .insnExc, .insnCtrlIn, .insnStatusIn);

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ========================================
  // ahb-lite master
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1 && n < 50)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 50)
    begin
      miscompares++;
      give_verdict();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    {hsel, hwrite, haddr} <= {1'b1, wr, 24'h0, a};
    {htrans, hsize} <= {HTRANS_NONSEQ, busSize};
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  function automatic logic [31:0] m_read(input logic [7:0] a);
    case (a)
      ADDR_CTRL: return {16'h0, mCw};
      ADDR_STATUS: return {16'h0, mSw};
      ADDR_ISTAT: return {29'h0, mIstat};
      ADDR_IEN: return {29'h0, mIen};
      default: return 32'h0;
    endcase
  endfunction

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    case (a)
      ADDR_CTRL: mCw = d[15:0];
      ADDR_STATUS: mSw = mSw & ~(d[15:0] & SW_W1C_MASK);
      ADDR_IEN: mIen = d[2:0];
      ADDR_ICLR: mIstat = mIstat & ~d[2:0];
      default: ;
    endcase
    mSw[7] = |mSw[5:0];
    bus(1'b1, a, d, rd);
  endtask

  task automatic reg_chk(input logic [7:0] a);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, rd);
    `CHK("register read", m_read(a), rd)
    `CHK("hresp", HRESP_OKAY, hresp)
  endtask

  task automatic chk_irq();
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("irq", |(mIstat & mIen), irq)
  endtask

  // ========================================
  // reference model of one instruction, then compare
  task automatic exec(input fefc_op_t op, input logic nw,
    input fefc_fmt_t fmt, input logic [5:0] stk, input logic [5:0] exc,
    input logic [15:0] cin);
    logic [5:0] rs;
    logic [3:0] e, seen;
    logic [15:0] cOut, sOut;
    logic ov, un, ar, waits;
    ov = stk[2] && stk[1:0] != TAG_EMPTY;
    un = stk[5] && stk[4:3] == TAG_EMPTY;
    cOut = mCw;
    sOut = mSw;
    waits = !(op inside {OP_LEGACY_EN, OP_LEGACY_DIS, OP_LEGACY_PM}) && !(nw
      && op inside {OP_STORE_CW, OP_STORE_SW, OP_SAVE, OP_INIT, OP_CLEAR});
    e = 4'b1000;
    if (waits && |(mSw[5:0] & ~mCw[5:0]))
      e = 4'b0100;
    else if (op inside {OP_ARITH, OP_NONARITH, OP_LOAD_OPERAND,
      OP_STORE_OPERAND})
    begin
      ar = op == OP_ARITH || (op != OP_NONARITH && fmt inside {FMT_SINGLE,
        FMT_DOUBLE});
      rs = ar ? exc : 6'h00;
      rs[0] = rs[0] | ov | un;
      mSw[5:0] = mSw[5:0] | rs;
      if (ov || un)
      begin
        mSw[6] = 1'b1;
        mSw[9] = ov;
      end
      mIstat[2:1] = mIstat[2:1] | {|rs, ov | un};
      if (rs[0] && !mCw[0])
        e = 4'b1110;
    end
    else if (op inside {OP_LOAD_CW, OP_RESTORE, OP_XRESTORE})
    begin
      mCw = cin;
      if (op != OP_LOAD_CW)
        mSw = cin;
    end
    else if (op inside {OP_SAVE, OP_INIT})
    begin
      mCw = CW_RESET;
      mSw = SW_RESET;
    end
    else if (op == OP_CLEAR)
      mSw = mSw & ~SW_CLR_MASK;
    mSw[7] = |mSw[5:0];
    mIstat[0] = mIstat[0] | e[2];
    e[0] = e[3] && op inside {OP_STORE_CW, OP_STORE_SW, OP_SAVE, OP_XSAVE};
    u_fefc_stream_model.issue(op, nw, fmt, stk, exc, cin, cin);
    #1;
    seen = {insnDone, serviceReq, keepStack, storeValid};
    `CHK("pulses", e, seen)
    if (e[0] && op != OP_STORE_SW)
      `CHK("ctrlWordOut", cOut, ctrlWordOut)
    if (e[0] && op != OP_STORE_CW)
      `CHK("statusWordOut", sOut, statusWordOut)
  endtask

  task automatic simple(input fefc_op_t op, input logic nw);
    exec(op, nw, FMT_REG, 6'h00, 6'h00, 16'h0000);
  endtask

  // ========================================
  // main sequence
  initial
  begin
    seed = 32'h42587997;
    miscompares = 0;
    testsRun = 0;
    {rst_n, hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
    mCw = CW_RESET;
    mSw = SW_RESET;
    {mIstat, mIen} = '0;
    busSize = HSIZE_WORD;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 24; i += 4)
      reg_chk(8'(i));
    reg_wr(ADDR_ISTAT, 32'h7);
    reg_wr(ADDR_CTRL, 32'h2a);
    reg_chk(ADDR_ISTAT);
    reg_chk(ADDR_CTRL);
    reg_wr(ADDR_CTRL, 32'h3f);
    // sub-word transfers are answered but write and return nothing
    busSize = 3'h0;
    bus(1'b1, ADDR_CTRL, 32'h0, r);
    bus(1'b0, ADDR_CTRL, 32'h0, r);
    busSize = HSIZE_WORD;
    `CHK("sized read", 32'h0, r)
    reg_chk(ADDR_CTRL);
    // all masked: each class flags, nothing pending
    for (i = 0; i < 6; i++)
    begin
      exec(OP_ARITH, 1'b0, FMT_REG, 6'h00, 6'h01 << i, 16'h0);
      simple(OP_STORE_SW, 1'b0);
    end
    simple(OP_CLEAR, 1'b1);
    exec(OP_ARITH, 1'b0, FMT_REG, 6'h04, 6'h00, 16'h0);
    reg_chk(ADDR_STATUS);
    reg_wr(ADDR_STATUS, 32'h1);
    exec(OP_ARITH, 1'b0, FMT_REG, 6'h00, 6'h01, 16'h0);
    reg_chk(ADDR_STATUS);
    exec(OP_NONARITH, 1'b0, FMT_REG, 6'h38, 6'h3f, 16'h0);
    simple(OP_STORE_SW, 1'b1);
    for (i = 0; i < 4; i++)
    begin
      simple(OP_CLEAR, 1'b1);
      exec(OP_LOAD_OPERAND, 1'b0, fefc_fmt_t'(i), 6'h0, 6'h3e, 16'h0);
      exec(OP_STORE_OPERAND, 1'b0, fefc_fmt_t'(i), 6'h0, 6'h3f, 16'h0);
      simple(OP_STORE_SW, 1'b1);
    end
    // unmasked invalid, then every op in turn; it stays pending until the save op resets both words
    simple(OP_CLEAR, 1'b1);
    exec(OP_LOAD_CW, 1'b0, FMT_REG, 6'h00, 6'h00, 16'h003e);
    exec(OP_ARITH, 1'b0, FMT_REG, 6'h00, 6'h01, 16'h0);
    exec(OP_LOAD_CW, 1'b0, FMT_REG, 6'h00, 6'h00, 16'h003f);
    for (i = 0; i < 17; i++)
      simple(fefc_op_t'((i + 14) % 17), 1'b1);
    // interrupt raise, clear and mask
    reg_chk(ADDR_ISTAT);
    reg_wr(ADDR_IEN, 32'h7);
    chk_irq();
    reg_wr(ADDR_ICLR, 32'h5);
    reg_chk(ADDR_ISTAT);
    reg_wr(ADDR_ICLR, 32'h7);
    chk_irq();
    exec(OP_ARITH, 1'b0, FMT_REG, 6'h04, 6'h00, 16'h0);
    chk_irq();
    reg_wr(ADDR_IEN, 32'h1);
    chk_irq();
    reg_chk(ADDR_IEN);
    // random instruction mix with occasional status clears
    for (i = 0; i < 80; i++)
    begin
      r = $random(seed);
      exec(fefc_op_t'(r[31:27] % 5'd17), r[26], fefc_fmt_t'(r[25:24]),
        r[23:18], r[17:12], {10'h000, r[11:6]});
      if (r[5:4] == 2'b00)
        reg_wr(ADDR_STATUS, {22'h0, r[9:0]});
    end
    reg_chk(ADDR_CTRL);
    reg_chk(ADDR_STATUS);
    reg_chk(ADDR_ISTAT);
    give_verdict();
  end
endmodule
